//--- core/sram_ctl_consts.svh
// constants for the burst sram control decode
`ifndef SRAM_CTL_CONSTS_SVH
`define SRAM_CTL_CONSTS_SVH
`define ADDR_W 20
`define DATA_W 36
`define LANES 4
`define LANE_W 9
`define NARROW_LANES 2
`define BURST_CNT_W 2
`define BURST_CNT_RST 2'h0
`define BURST_CNT_LOAD 2'h1
`define LANE_MASK_RST 4'h0
`endif

//--- core/sram_ctl_pkg.sv
// types for the burst sram control decode
package sram_ctl_pkg;
  // operation chosen by the synchronous decode
  typedef enum logic [2:0]
  {
    OP_DESELECT = 3'b000,
    OP_READ_EXT = 3'b001,
    OP_WRITE_EXT = 3'b010,
    OP_READ_NEXT = 3'b011,
    OP_WRITE_NEXT = 3'b100,
    OP_READ_HOLD = 3'b101,
    OP_WRITE_HOLD = 3'b110
  } op_t;
endpackage : sram_ctl_pkg

//--- core/burst_ctr_if.sv
// interface between the decode and the burst counter
`timescale 1ns/1ns
`default_nettype none
interface burst_ctr_if;
  logic load; // take start lsbs
  logic step; // advance one address
  logic [1:0] start_lsb; // external lsbs
  logic interleave; // interleaved order
  logic [1:0] lsb; // current burst lsbs
  modport ctl (output load, output step, output start_lsb, output interleave, input lsb);
  modport ctr (input load, input step, input start_lsb, input interleave, output lsb);
endinterface : burst_ctr_if
`default_nettype wire

//--- core/burst_counter.sv
// two-bit burst address counter, linear or interleaved
`include "sram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module burst_counter
(
  input wire logic mclk,
  input wire logic rst,
  burst_ctr_if.ctr bc
);
  logic [1:0] base; // start lsbs of the burst
  logic [1:0] cnt; // offset the next step presents, wraps after four
  logic [1:0] next_base;
  logic [1:0] next_cnt;

  // ----------------------------------------
  // next count and base
  // ----------------------------------------
  always_comb
  begin
    next_base = base;
    next_cnt = cnt;
    if (bc.load)
    begin
      next_base = bc.start_lsb;
      // the load cycle itself shows offset zero, so the count starts at one
      next_cnt = `BURST_CNT_LOAD;
    end
    else if (bc.step)
    begin
      next_cnt = 2'(cnt + 2'h1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      base <= `BURST_CNT_RST;
      cnt <= `BURST_CNT_LOAD;
    end
    else
    begin
      base <= next_base;
      cnt <= next_cnt;
    end
  end

  assign bc.lsb = bc.interleave ? (base ^ cnt) : 2'(base + cnt);

  a_burst_wrap: assert property (@(posedge mclk) disable iff (rst)
    (bc.step && !bc.load) [*4] |=> (bc.lsb == $past(bc.lsb, 4)))
    else $error("burst counter did not wrap after four steps");
endmodule : burst_counter
`default_nettype wire

//--- core/lane_decode.sv
// write decision and byte lane mask from the write inputs
`include "sram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module lane_decode
(
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [`LANES-1:0] lane_write_n,
  input wire logic wide_org,
  output logic write_q,
  output logic [`LANES-1:0] lane_mask
);
  logic [`LANES-1:0] present; // lanes that exist in this organisation

  // ----------------------------------------
  // lane existence
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LANES; g++)
    begin : g_lane
      assign present[g] = (g < `NARROW_LANES) ? 1'b1 : wide_org;
    end
  endgenerate

  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb
  begin
    if (!all_bytes_write_n)
      lane_mask = present;
    else if (!byte_write_gate_n)
      lane_mask = ~lane_write_n & present;
    else
      lane_mask = `LANE_MASK_RST;
    write_q = !all_bytes_write_n || !byte_write_gate_n;
  end
endmodule : lane_decode
`default_nettype wire

//--- core/sync_burst_sram_control_decode.sv
// synchronous control decode of a pipelined burst sram
`include "sram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_control_decode
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic primary_select_n,
  input wire logic second_select_high,
  input wire logic third_select_n,
  input wire logic strobe_from_cpu_n,
  input wire logic strobe_from_cache_ctl_n,
  input wire logic burst_step_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic byte_lane0_write_n,
  input wire logic byte_lane1_write_n,
  input wire logic byte_lane2_write_n,
  input wire logic byte_lane3_write_n,
  input wire logic linear_order_select_n,
  input wire logic wide_org,
  input wire logic output_enable_n,
  input wire logic [`DATA_W-1:0] dq_in,
  input wire logic [`DATA_W-1:0] rd_data,
  output logic [`DATA_W-1:0] dq_out,
  output logic [`LANES-1:0] dq_oe,
  output logic [`ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [`LANES-1:0] mem_lane_we,
  output logic [`DATA_W-1:0] mem_wdata,
  output logic deselected
);
  // ----------------------------------------
  // local state
  // ----------------------------------------
  sram_ctl_pkg::op_t op; // decoded operation this cycle
  sram_ctl_pkg::op_t op_r; // registered operation
  sram_ctl_pkg::op_t next_op_r;
  logic write_q; // write qualifier from lane decode
  logic [`LANES-1:0] lane_mask; // lanes to write
  logic full_sel; // all three selects true
  logic [`ADDR_W-1:0] base_addr; // burst start address
  logic [`ADDR_W-1:0] next_base_addr;
  logic [`ADDR_W-1:0] next_mem_addr;
  logic next_mem_rd;
  logic next_mem_wr;
  logic [`LANES-1:0] next_mem_lane_we;
  logic [`DATA_W-1:0] next_mem_wdata;
  logic next_deselected;
  logic read_phase; // last captured cycle is a read
  logic next_read_phase;
  logic [`DATA_W-1:0] next_dq_out;
  logic [`LANES-1:0] next_dq_oe;

  burst_ctr_if bci ();

  lane_decode u_lane
  (
    .all_bytes_write_n(all_bytes_write_n),
    .byte_write_gate_n(byte_write_gate_n),
    .lane_write_n({byte_lane3_write_n, byte_lane2_write_n,
                   byte_lane1_write_n, byte_lane0_write_n}),
    .wide_org(wide_org),
    .write_q(write_q),
    .lane_mask(lane_mask)
  );

  burst_counter u_ctr
  (
    .mclk(mclk),
    .rst(rst),
    .bc(bci.ctr)
  );

  // ----------------------------------------
  // synchronous truth table decode
  // ----------------------------------------
  always_comb
  begin
    // all three selects agree
    full_sel = !primary_select_n && second_select_high && !third_select_n;
    // deselect: primary low but selects fail with either strobe, or primary high with cache strobe
    if (!primary_select_n && !full_sel && (!strobe_from_cpu_n || !strobe_from_cache_ctl_n))
      op = sram_ctl_pkg::OP_DESELECT;
    else if (primary_select_n && !strobe_from_cache_ctl_n)
      op = sram_ctl_pkg::OP_DESELECT;
    // cpu strobe reads at external address
    else if (full_sel && !strobe_from_cpu_n)
      op = sram_ctl_pkg::OP_READ_EXT;
    // cache strobe begins read or write
    else if (full_sel && !strobe_from_cache_ctl_n)
      op = write_q ? sram_ctl_pkg::OP_WRITE_EXT : sram_ctl_pkg::OP_READ_EXT;
    else if (!burst_step_n)
      op = write_q ? sram_ctl_pkg::OP_WRITE_NEXT : sram_ctl_pkg::OP_READ_NEXT;
    else
      op = write_q ? sram_ctl_pkg::OP_WRITE_HOLD : sram_ctl_pkg::OP_READ_HOLD;
  end

  // ----------------------------------------
  // burst counter control
  // ----------------------------------------
  // either begin-burst command presets the counter
  assign bci.load = (op == sram_ctl_pkg::OP_READ_EXT) || (op == sram_ctl_pkg::OP_WRITE_EXT);
  // step regardless of output enable
  // only continue commands advance; suspend holds
  assign bci.step = (op == sram_ctl_pkg::OP_READ_NEXT) || (op == sram_ctl_pkg::OP_WRITE_NEXT);
  // low address bits seed the burst
  assign bci.start_lsb = addr[1:0];
  assign bci.interleave = linear_order_select_n;

  // ----------------------------------------
  // memory command next values
  // ----------------------------------------
  // deselect keeps the last address so a later suspend reuses it
  always_comb
  begin
    next_base_addr = base_addr;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_lane_we = `LANE_MASK_RST;
    next_mem_wdata = mem_wdata;
    next_deselected = 1'b0;
    next_read_phase = 1'b0;
    unique case (op)
      sram_ctl_pkg::OP_DESELECT:
      begin
        next_deselected = 1'b1;
      end
      sram_ctl_pkg::OP_READ_EXT, sram_ctl_pkg::OP_WRITE_EXT:
      begin
        next_base_addr = addr;
        next_mem_addr = addr;
      end
      sram_ctl_pkg::OP_READ_NEXT, sram_ctl_pkg::OP_WRITE_NEXT:
      begin
        next_mem_addr = {base_addr[`ADDR_W-1:2], bci.lsb};
      end
      sram_ctl_pkg::OP_READ_HOLD, sram_ctl_pkg::OP_WRITE_HOLD:
      begin
        next_mem_addr = mem_addr;
      end
    endcase
    if (op != sram_ctl_pkg::OP_DESELECT)
    begin
      next_mem_rd = !write_q || (op == sram_ctl_pkg::OP_READ_EXT);
      next_mem_wr = !next_mem_rd;
      next_read_phase = next_mem_rd;
      if (next_mem_wr)
      begin
        next_mem_lane_we = lane_mask;
        next_mem_wdata = dq_in;
      end
    end
    // keep the op for the covers
    next_op_r = op;
  end

  // ----------------------------------------
  // memory command registers
  // ----------------------------------------
  // rising edge capture
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      base_addr <= '0;
      mem_addr <= '0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_lane_we <= `LANE_MASK_RST;
      mem_wdata <= '0;
      deselected <= 1'b1;
      read_phase <= 1'b0;
      op_r <= sram_ctl_pkg::OP_DESELECT;
    end
    else
    begin
      base_addr <= next_base_addr;
      mem_addr <= next_mem_addr;
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      mem_lane_we <= next_mem_lane_we;
      mem_wdata <= next_mem_wdata;
      deselected <= next_deselected;
      read_phase <= next_read_phase;
      op_r <= next_op_r;
    end
  end

  // ----------------------------------------
  // data output drivers
  // ----------------------------------------
  // writes never drive
  // read data and enables one stage after the command
  always_comb
  begin
    next_dq_out = read_phase ? rd_data : dq_out;
    next_dq_oe = read_phase ? {`LANES{1'b1}} : `LANE_MASK_RST;
  end

  // enable high clears drivers at once
  always_ff @(posedge mclk or posedge rst or posedge output_enable_n)
  begin
    if (rst)
    begin
      dq_out <= '0;
      dq_oe <= `LANE_MASK_RST;
    end
    else if (output_enable_n)
    begin
      dq_out <= '0;
      dq_oe <= `LANE_MASK_RST;
    end
    else
    begin
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_write_floats: assert property (@(posedge mclk) disable iff (rst)
    mem_wr |=> dq_oe == `LANE_MASK_RST)
    else $error("data bus driven during a write");
  a_oe_kills: assert property (@(posedge mclk) disable iff (rst)
    output_enable_n |-> dq_oe == `LANE_MASK_RST)
    else $error("drivers on with output enable high");
  a_oe_read_only: assert property (@(posedge mclk) disable iff (rst)
    (dq_oe != `LANE_MASK_RST) |-> $past(read_phase))
    else $error("drivers on outside a read cycle");
  a_deselect_cs: assert property (@(posedge mclk) disable iff (rst)
    (primary_select_n && !strobe_from_cache_ctl_n) |=> deselected && !mem_rd && !mem_wr)
    else $error("no deselect with primary select high and cache strobe");
  a_cpu_read: assert property (@(posedge mclk) disable iff (rst)
    (full_sel && !strobe_from_cpu_n) |=> mem_rd && mem_addr == $past(addr))
    else $error("cpu strobe did not start read at external address");
  a_cache_write: assert property (@(posedge mclk) disable iff (rst)
    (full_sel && strobe_from_cpu_n && !strobe_from_cache_ctl_n && write_q)
      |=> mem_wr && mem_wdata == $past(dq_in))
    else $error("cache strobe write not started");
  a_global_all: assert property (@(posedge mclk) disable iff (rst)
    (op == sram_ctl_pkg::OP_WRITE_EXT && !all_bytes_write_n && wide_org)
      |=> mem_lane_we == 4'hF)
    else $error("global write missed a lane");
  a_read_gates: assert property (@(posedge mclk) disable iff (rst)
    (all_bytes_write_n && byte_write_gate_n && op != sram_ctl_pkg::OP_DESELECT)
      |=> mem_rd && mem_lane_we == `LANE_MASK_RST)
    else $error("both gates high not treated as read");
  a_narrow_lanes: assert property (@(posedge mclk) disable iff (rst)
    !wide_org |=> mem_lane_we[3:2] == 2'h0)
    else $error("upper lane written on narrow part");
  a_hold_addr: assert property (@(posedge mclk) disable iff (rst)
    (op == sram_ctl_pkg::OP_WRITE_HOLD) |=> mem_addr == $past(mem_addr) && mem_wr)
    else $error("suspend write moved the address");
  a_read_hold: assert property (@(posedge mclk) disable iff (rst)
    (op == sram_ctl_pkg::OP_READ_HOLD) |=> mem_addr == $past(mem_addr) && mem_rd)
    else $error("suspend read moved the address");
  a_step_read: assert property (@(posedge mclk) disable iff (rst)
    (op == sram_ctl_pkg::OP_READ_NEXT) |=> mem_rd && mem_addr[1:0] != $past(mem_addr[1:0]))
    else $error("continue read did not step the address");
  // scenarios worth seeing in simulation
  c_suspend: cover property (@(posedge mclk) disable iff (rst)
    op == sram_ctl_pkg::OP_READ_HOLD ##1 op == sram_ctl_pkg::OP_READ_NEXT);
  c_burst_read: cover property (@(posedge mclk) disable iff (rst)
    op == sram_ctl_pkg::OP_READ_EXT ##1 op == sram_ctl_pkg::OP_READ_NEXT [*3]);
  c_burst_write: cover property (@(posedge mclk) disable iff (rst)
    op == sram_ctl_pkg::OP_WRITE_EXT ##1 op == sram_ctl_pkg::OP_WRITE_NEXT);
  c_dummy_read: cover property (@(posedge mclk) disable iff (rst)
    output_enable_n && op == sram_ctl_pkg::OP_READ_NEXT ##1 op == sram_ctl_pkg::OP_WRITE_EXT);
  c_deselect: cover property (@(posedge mclk) disable iff (rst)
    op_r == sram_ctl_pkg::OP_DESELECT);
endmodule : sync_burst_sram_control_decode
`default_nettype wire

//--- dv/sram_array_model.sv
// storage array model standing on the far side of the array port
`include "sram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module sram_array_model
(
  input wire logic mclk,
  input wire logic [`ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [`LANES-1:0] mem_lane_we,
  input wire logic [`DATA_W-1:0] mem_wdata,
  output logic [`DATA_W-1:0] rd_data
);
  // ----------
  // sparse store
  // ----------
  logic [`DATA_W-1:0] store [logic [`ADDR_W-1:0]]; // written words only
  logic [`DATA_W-1:0] word; // merge scratch
  logic [7:0] wr_cnt = 8'h00; // bumps on each write, wakes the read port
  // lane-masked write at the edge; unwritten words hold an address pattern
  always @(posedge mclk)
  begin
    if (mem_wr)
    begin
      word = store.exists(mem_addr) ? store[mem_addr] : {mem_addr[15:0], mem_addr};
      for (int i = 0; i < `LANES; i++)
        if (mem_lane_we[i]) word[i*`LANE_W +: `LANE_W] = mem_wdata[i*`LANE_W +: `LANE_W];
      store[mem_addr] = word;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
  // read port; inverted junk when not reading so stale data never passes
  always @(mem_addr, mem_rd, wr_cnt)
  begin
    rd_data = store.exists(mem_addr) ? store[mem_addr] : {mem_addr[15:0], mem_addr};
    if (!mem_rd) rd_data = ~rd_data;
  end
endmodule : sram_array_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the burst sram control decode
`include "sram_ctl_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------
  // stimulus and observed signals
  // ----------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel_n = 1'b1, ssel = 1'b1, tsel_n = 1'b0; // idle: deselected
  logic cpu_n = 1'b1, cac_n = 1'b0, step_n = 1'b1; // address strobes, advance
  logic allw_n = 1'b1, gate_n = 1'b1, ord_n = 1'b0, wide = 1'b1, oe_n = 1'b0;
  logic [3:0] lane_n = 4'hF; // lane write controls
  logic [`ADDR_W-1:0] addr = 20'h00000;
  logic [`DATA_W-1:0] dq_in = 36'h000000000;
  logic [`DATA_W-1:0] rd_data, dq_out, mem_wdata;
  logic [`ADDR_W-1:0] mem_addr;
  logic [3:0] dq_oe, mem_lane_we;
  logic mem_rd, mem_wr, deselected;
  // ----------
  // expectation state
  // ----------
  typedef struct packed
  {
    logic ds;
    logic rd;
    logic wr;
    logic [`ADDR_W-1:0] a;
    logic [3:0] m;
    logic [`DATA_W-1:0] d;
    logic [`DATA_W-1:0] q;
  } exp_t;
  exp_t c = '{ds: 1'b1, default: '0}; // newest command
  exp_t p = '{ds: 1'b1, default: '0}; // visible on mem outputs now
  exp_t pp = '{ds: 1'b1, default: '0}; // visible on data bus now
  logic [`DATA_W-1:0] sh [logic [`ADDR_W-1:0]]; // shadow of array contents
  logic [`ADDR_W-1:0] base = 20'h00000; // burst start address
  logic [1:0] n = 2'h0; // burst count
  logic ord_v = 1'b0, wide_v = 1'b1; // strap values to apply
  logic [31:0] seed = 32'h0001167F;
  int bad_count = 0;
  int compares = 0;
  localparam logic [2:0] FULL = 3'b010; // fully selected
  localparam logic [5:0] RD = 6'h3F; // no write control low
  localparam logic [5:0] WALL = 6'h1F; // all-bytes write low
  logic [5:0] desel_tab [5] = '{6'h1D, 6'h05, 6'h1B, 6'h03, 6'h35};
  sync_burst_sram_control_decode sync_burst_sram_control_decode_i
  (
    .mclk(mclk), .rst(rst), .addr(addr), .primary_select_n(psel_n),
    .second_select_high(ssel), .third_select_n(tsel_n), .strobe_from_cpu_n(cpu_n),
    .strobe_from_cache_ctl_n(cac_n), .burst_step_n(step_n), .all_bytes_write_n(allw_n),
    .byte_write_gate_n(gate_n), .byte_lane0_write_n(lane_n[0]),
    .byte_lane1_write_n(lane_n[1]), .byte_lane2_write_n(lane_n[2]),
    .byte_lane3_write_n(lane_n[3]), .linear_order_select_n(ord_n), .wide_org(wide),
    .output_enable_n(oe_n), .dq_in(dq_in), .rd_data(rd_data), .dq_out(dq_out),
    .dq_oe(dq_oe), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_lane_we(mem_lane_we), .mem_wdata(mem_wdata), .deselected(deselected)
  );
  sram_array_model sram_array_model_i
  (
    .mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_lane_we(mem_lane_we), .mem_wdata(mem_wdata), .rd_data(rd_data)
  );
  // free-running clock, 50 ns period
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // one command per edge; checks the two older commands now visible
  task automatic drive(input logic [2:0] s, input logic [2:0] k, input logic [5:0] w,
    input logic [`ADDR_W-1:0] a, input logic o);
    logic wq;
    logic ol; // output enable as the design saw it at this edge
    logic [3:0] m;
    logic [`DATA_W-1:0] d, q;
    @(posedge mclk);
    ol = oe_n;
    seed = lfsr(seed);
    d = {seed[3:0], seed};
    {psel_n, ssel, tsel_n} <= s;
    {cpu_n, cac_n, step_n} <= k;
    {allw_n, gate_n, lane_n} <= w;
    addr <= a;
    dq_in <= d;
    oe_n <= o;
    ord_n <= ord_v;
    wide <= wide_v;
    pp = p;
    p = c;
    c = '{default: '0};
    wq = !w[5] || !w[4];
    m = !w[5] ? 4'hF : (!w[4] ? ~w[3:0] : 4'h0);
    if (!wide_v) m[3:2] = 2'h0;
    if ((!s[2] && (!s[1] || s[0]) && (!k[1] || !k[2])) || (s[2] && !k[1]))
      c.ds = 1'b1;
    else
    begin
      if (!s[2] && (!k[2] || !k[1]))
      begin
        base = a;
        n = 2'h0;
      end
      else if (!k[0])
        n = n + 2'h1;
      c.rd = !wq || (!s[2] && !k[2]);
      c.wr = !c.rd;
      c.a = {base[19:2], ord_v ? base[1:0] ^ n : base[1:0] + n};
      c.m = m;
      c.d = d;
      q = sh.exists(c.a) ? sh[c.a] : {c.a[15:0], c.a};
      c.q = q;
      for (int i = 0; i < `LANES; i++)
        if (c.wr && m[i]) q[i*`LANE_W +: `LANE_W] = d[i*`LANE_W +: `LANE_W];
      if (c.wr) sh[c.a] = q;
    end
    #1;
    check("deselected", deselected, p.ds);
    check("mem_rd", mem_rd, p.rd);
    check("mem_wr", mem_wr, p.wr);
    if (p.rd || p.wr) check("mem_addr", mem_addr, p.a);
    check("mem_lane_we", mem_lane_we, p.wr ? p.m : 4'h0);
    if (p.wr) check("mem_wdata", mem_wdata, p.d);
    check("dq_oe", dq_oe, (pp.rd && !oe_n && !ol) ? 4'hF : 4'h0);
    if (oe_n || ol || pp.rd) check("dq_out", dq_out, (oe_n || ol) ? 36'h0 : pp.q);
  endtask : drive
  // ----------
  // main sequence
  // ----------
  initial
  begin
    repeat (6) @(posedge mclk);
    check("deselected", deselected, 1'b1);
    rst <= 1'b0;
    for (int o = 0; o < 2; o++)
    begin
      ord_v = o[0];
      // cache strobe loads, then five dummy-read steps wrap the count
      drive(FULL, 3'b101, RD, 20'h5A5A6, 1'b0);
      repeat (5) drive(FULL, 3'b110, RD, 20'h00000, 1'b1);
      drive(FULL, 3'b111, RD, 20'h00000, 1'b0);
      // read to write with output held off
      drive(3'b110, 3'b110, WALL, 20'h00000, 1'b1);
      drive(FULL, 3'b111, 6'h2A, 20'h00000, 1'b1);
      drive(3'b110, 3'b010, RD, 20'h00000, 1'b0);
    end
    drive(FULL, 3'b011, WALL, 20'h00123, 1'b0);
    repeat (4)
    begin
      seed = lfsr(seed);
      drive(FULL, 3'b101, seed[5:0], {16'h0000, seed[9:6]}, 1'b0);
    end
    for (int i = 0; i < 5; i++)
      drive(desel_tab[i][5:3], desel_tab[i][2:0], RD, 20'h00001, 1'b0);
    for (int i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      if (i == 150) wide_v = 1'b0;
      drive(seed[2:0] == 3'h0 ? seed[5:3] : FULL, seed[8:6], seed[14:9],
        {16'h0000, seed[18:15]}, seed[19] & seed[20]);
    end
    repeat (2) drive(FULL, 3'b111, RD, 20'h00000, 1'b1);
    results();
  end
  // watchdog against a hung run
  initial
  begin
    #5000000;
    bad_count++;
    results();
  end
endmodule : testbench
`default_nettype wire
